// ---- fieldbus_job_command_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module fieldbus_job_command_decoder (
   input wire logic clk,
   input wire logic reset_n,
   fieldbus_if.device bus,
   input wire logic line_tally_en,
   input wire logic [fieldbus_cmd_pkg::PAUSE_W-1:0] pause_time,
   input wire logic job_continue,
   input wire logic [fieldbus_cmd_pkg::TALLY_W-1:0] batch_default,
   input wire logic batch_complete,
   input wire logic job_request,
   input wire logic reverse_dir,
   input wire logic process_done,
   input wire logic process_timeout,
   input wire logic [2:0] selection_source_setting,
   output logic job_running_ff,
   output logic [fieldbus_cmd_pkg::STEP_W-1:0] job_step_ff,
   output logic [fieldbus_cmd_pkg::TALLY_W-1:0] batch_count_ff,
   output logic [fieldbus_cmd_pkg::TALLY_W-1:0] job_count_ff,
   output logic tool_locked_ff,
   output logic job_mode_ff,
   output logic panel_switch_en,
   output logic job_pass_ff,
   output logic result_dump_ff,
   output logic seat_sync_ff,
   output logic rotating_ff,
   output logic forced_stop_ff,
   output logic tighten_en_ff,
   output logic loosen_en_ff,
   output logic [fieldbus_cmd_pkg::IDENT_W-1:0] identifier_ff,
   output logic ident_valid_ff,
   output logic [2:0] active_source_ff
);
   import fieldbus_cmd_pkg::*;

   logic [CMD_W-1:0] cmd_s1_ff, cmd_s2_ff, cmd_s3_ff;
   logic [LVL_W-1:0] lvl_s1_ff, lvl_s2_ff;
   logic [IDENT_W-1:0] id_s1_ff, id_s2_ff;
   logic [CMD_W-1:0] rise;
   logic tighten_inh, loosen_inh, rot_block;
   logic internal_channel_source, external_channel_source;
   logic internal_job_source, external_job_source, identifier_source;
   logic begin_seen_ff;
   logic start_ok, run_ok, end_job;
   source_e nxt_source;

   // ======================================================
   // input synchronisers and rising-edge detect
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_s1_ff <= '0;
         cmd_s2_ff <= '0;
         cmd_s3_ff <= '0;
         lvl_s1_ff <= '0;
         lvl_s2_ff <= '0;
         id_s1_ff <= '0;
         id_s2_ff <= '0;
      end else begin
         cmd_s1_ff <= bus.cmd_pulse;
         cmd_s2_ff <= cmd_s1_ff;
         cmd_s3_ff <= cmd_s2_ff;
         lvl_s1_ff <= bus.cmd_level;
         lvl_s2_ff <= lvl_s1_ff;
         id_s1_ff <= bus.ident_data;
         id_s2_ff <= id_s1_ff;
      end
   end

   // a held level acts once; only the rise counts
   assign rise = cmd_s2_ff & ~cmd_s3_ff;
   assign tighten_inh = lvl_s2_ff[LVL_TIGHTEN_INH];
   assign loosen_inh = lvl_s2_ff[LVL_LOOSEN_INH];
   assign rot_block = lvl_s2_ff[LVL_ROT_BLOCK];
   assign internal_channel_source = lvl_s2_ff[LVL_SRC_LO];
   assign external_channel_source = lvl_s2_ff[LVL_SRC_LO+1];
   assign internal_job_source = lvl_s2_ff[LVL_SRC_LO+2];
   assign external_job_source = lvl_s2_ff[LVL_SRC_LO+3];
   assign identifier_source = lvl_s2_ff[LVL_SRC_LO+4];

   // ======================================================
   // selection source; lowest override wins if several set
   always_comb begin
      if (internal_channel_source) begin
         nxt_source = SRC_INT_CH;
      end else if (external_channel_source) begin
         nxt_source = SRC_EXT_CH;
      end else if (internal_job_source) begin
         nxt_source = SRC_INT_JOB;
      end else if (external_job_source) begin
         nxt_source = SRC_EXT_JOB;
      end else if (identifier_source) begin
         nxt_source = SRC_IDENT;
      end else begin
         nxt_source = source_e'(selection_source_setting);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         active_source_ff <= SRC_INT_CH;
      end else begin
         active_source_ff <= nxt_source;
      end
   end

   // ======================================================
   // identifier latch
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         identifier_ff <= '0;
         ident_valid_ff <= 1'b0;
      end else begin
         ident_valid_ff <= rise[CMD_IDENT_STROBE];
         if (rise[CMD_IDENT_STROBE]) begin
            identifier_ff <= id_s2_ff;
         end
      end
   end

   // ======================================================
   // job mode and job execution
   assign start_ok = job_mode_ff && !job_running_ff && job_request
                     && (!line_tally_en || begin_seen_ff);
   assign end_job = rise[CMD_JOB_CANCEL] || rise[CMD_JOB_EXIT];
   assign panel_switch_en = !job_mode_ff;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         begin_seen_ff <= 1'b0;
      end else if (rise[CMD_JOB_BEGIN]) begin
         begin_seen_ff <= 1'b1;
      end else if (start_ok) begin
         begin_seen_ff <= 1'b0;
      end
   end

   // job mode comes back on job begin from a job source or on an identifier strobe from the identifier source
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         job_mode_ff <= 1'b1;
      end else if (rise[CMD_JOB_EXIT]) begin
         job_mode_ff <= 1'b0;
      end else if (rise[CMD_JOB_BEGIN] && (active_source_ff == SRC_INT_JOB
                   || active_source_ff == SRC_EXT_JOB)) begin
         job_mode_ff <= 1'b1;
      end else if (rise[CMD_IDENT_STROBE] && active_source_ff == SRC_IDENT) begin
         job_mode_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         job_running_ff <= 1'b0;
         job_step_ff <= '0;
         job_pass_ff <= 1'b0;
      end else begin
         job_pass_ff <= job_running_ff && end_job;
         if (end_job) begin
            job_running_ff <= 1'b0;
         end else if (start_ok) begin
            job_running_ff <= 1'b1;
            job_step_ff <= '0;
         end else if (job_running_ff && rise[CMD_JOB_RERUN]) begin
            job_step_ff <= '0;
         end else if (job_running_ff && rise[CMD_STEP_SKIP] && !job_continue) begin
            job_step_ff <= job_step_ff + 7'h01;
         end
      end
   end

   // ======================================================
   // batch and job tallies; fastening results are untouched
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         batch_count_ff <= '0;
         job_count_ff <= '0;
      end else begin
         if (rise[CMD_TALLY_CLEAR]) begin
            batch_count_ff <= batch_default;
         end else if (!job_running_ff && (rise[CMD_TALLY_UP] ^ rise[CMD_TALLY_DOWN])) begin
            batch_count_ff <= tally_step(batch_count_ff, rise[CMD_TALLY_UP]);
         end
         if (start_ok || (job_running_ff && rise[CMD_JOB_RERUN])) begin
            job_count_ff <= '0;
         end else if (job_running_ff && (rise[CMD_TALLY_UP] ^ rise[CMD_TALLY_DOWN])) begin
            job_count_ff <= tally_step(job_count_ff, rise[CMD_TALLY_UP]);
         end
      end
   end

   // completion wins over a clear in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tool_locked_ff <= 1'b0;
      end else if (batch_complete) begin
         tool_locked_ff <= 1'b1;
      end else if (rise[CMD_TALLY_CLEAR]) begin
         tool_locked_ff <= 1'b0;
      end
   end

   // ======================================================
   // serial-port requests
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         result_dump_ff <= 1'b0;
         seat_sync_ff <= 1'b0;
      end else begin
         result_dump_ff <= rise[CMD_RESULT_DUMP];
         seat_sync_ff <= rise[CMD_SEAT_SYNC] && (pause_time != '0);
      end
   end

   // ======================================================
   // rotation control
   assign run_ok = rise[CMD_PULSE_RUN] && !rot_block && !tool_locked_ff
                   && (reverse_dir ? !loosen_inh : !tighten_inh);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tighten_en_ff <= 1'b0;
         loosen_en_ff <= 1'b0;
      end else begin
         tighten_en_ff <= !tighten_inh && !rot_block && !tool_locked_ff;
         loosen_en_ff <= !loosen_inh && !rot_block && !tool_locked_ff;
      end
   end

   // the run pulse only starts; the input dropping does not stop it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rotating_ff <= 1'b0;
         forced_stop_ff <= 1'b0;
      end else begin
         forced_stop_ff <= rotating_ff && rot_block;
         if (rot_block || process_done || process_timeout) begin
            rotating_ff <= 1'b0;
         end else if (run_ok) begin
            rotating_ff <= 1'b1;
         end
      end
   end

   assign bus.status = {job_mode_ff, tool_locked_ff, rotating_ff, job_running_ff};
endmodule : fieldbus_job_command_decoder
`default_nettype wire

// ---- fieldbus_cmd_pkg.sv ----
package fieldbus_cmd_pkg;
   // ======================================================
   // command pulse bits on the fieldbus image
   localparam int CMD_W = 12;
   localparam int CMD_JOB_BEGIN = 0;
   localparam int CMD_RESULT_DUMP = 1;
   localparam int CMD_SEAT_SYNC = 2;
   localparam int CMD_TALLY_CLEAR = 3;
   localparam int CMD_PULSE_RUN = 4;
   localparam int CMD_TALLY_UP = 5;
   localparam int CMD_TALLY_DOWN = 6;
   localparam int CMD_JOB_RERUN = 7;
   localparam int CMD_STEP_SKIP = 8;
   localparam int CMD_JOB_CANCEL = 9;
   localparam int CMD_JOB_EXIT = 10;
   localparam int CMD_IDENT_STROBE = 11;
   // ======================================================
   // level bits on the fieldbus image
   localparam int LVL_W = 8;
   localparam int LVL_TIGHTEN_INH = 0;
   localparam int LVL_LOOSEN_INH = 1;
   localparam int LVL_ROT_BLOCK = 2;
   localparam int LVL_SRC_LO = 3;
   localparam int SRC_W = 5;
   // ======================================================
   // widths and status bits
   localparam int IDENT_W = 8;
   localparam int TALLY_W = 16;
   localparam int STEP_W = 7;
   localparam int PAUSE_W = 8;
   localparam int STAT_W = 4;
   localparam int STAT_JOB_RUN = 0;
   localparam int STAT_ROTATING = 1;
   localparam int STAT_LOCKED = 2;
   localparam int STAT_JOB_MODE = 3;
   // ======================================================
   // controller registers over axi4-lite
   localparam logic [3:0] OFS_CMD = 4'h0;
   localparam logic [3:0] OFS_LEVEL = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam logic [3:0] OFS_IDENT = 4'hC;
   localparam logic [LVL_W-1:0] LEVEL_RST = 8'h00;
   localparam logic [IDENT_W-1:0] IDENT_RST = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      SRC_INT_CH  = 3'b000,
      SRC_EXT_CH  = 3'b001,
      SRC_INT_JOB = 3'b010,
      SRC_EXT_JOB = 3'b011,
      SRC_IDENT   = 3'b100
   } source_e;

   function automatic logic [TALLY_W-1:0] tally_step(input logic [TALLY_W-1:0] v,
                                                     input logic up);
      tally_step = up ? v + 16'h0001 : v - 16'h0001;
   endfunction : tally_step
endpackage : fieldbus_cmd_pkg

// ---- fieldbus_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface fieldbus_if;
   import fieldbus_cmd_pkg::*;
   logic [CMD_W-1:0] cmd_pulse;
   logic [LVL_W-1:0] cmd_level;
   logic [IDENT_W-1:0] ident_data;
   logic [STAT_W-1:0] status;
   modport master (
      output cmd_pulse,
      output cmd_level,
      output ident_data,
      input status
   );
   modport device (
      input cmd_pulse,
      input cmd_level,
      input ident_data,
      output status
   );
endinterface : fieldbus_if
`default_nettype wire

// ---- fieldbus_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic multi_spindle_en,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   fieldbus_if.master bus
);
   import fieldbus_cmd_pkg::*;

   logic aw_got_ff, w_got_ff;
   logic [3:0] aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic [CMD_W-1:0] pulse_ff;
   logic [LVL_W-1:0] level_ff;
   logic [IDENT_W-1:0] ident_ff;
   logic do_write;
   logic [CMD_W-1:0] nxt_pulse;

   // ======================================================
   // write channel: address and data in either order
   assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
   assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
   assign do_write = aw_got_ff && w_got_ff && !s_axi_bvalid;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         aw_addr_ff <= 4'h0;
         w_data_ff <= 32'h0;
         w_strb_ff <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_ff == OFS_CMD || aw_addr_ff == OFS_LEVEL || aw_addr_ff == OFS_IDENT) begin
               s_axi_bresp <= RESP_OKAY;
            end else begin
               s_axi_bresp <= RESP_SLVERR;
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ======================================================
   // command image: pulse bits last one cycle per write
   always_comb begin
      nxt_pulse = '0;
      if (do_write && aw_addr_ff == OFS_CMD) begin
         if (w_strb_ff[0]) begin
            nxt_pulse[7:0] = w_data_ff[7:0];
         end
         if (w_strb_ff[1]) begin
            nxt_pulse[CMD_W-1:8] = w_data_ff[CMD_W-1:8];
         end
         // seat sync is withheld while multi-spindle runs
         nxt_pulse[CMD_SEAT_SYNC] = nxt_pulse[CMD_SEAT_SYNC] && !multi_spindle_en;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pulse_ff <= '0;
      end else begin
         pulse_ff <= nxt_pulse;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         level_ff <= LEVEL_RST;
         ident_ff <= IDENT_RST;
      end else if (do_write && w_strb_ff[0]) begin
         if (aw_addr_ff == OFS_LEVEL) begin
            level_ff <= w_data_ff[LVL_W-1:0];
         end else if (aw_addr_ff == OFS_IDENT) begin
            ident_ff <= w_data_ff[IDENT_W-1:0];
         end
      end
   end

   assign bus.cmd_pulse = pulse_ff;
   assign bus.cmd_level = level_ff;
   assign bus.ident_data = ident_ff;

   // ======================================================
   // read channel
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         if (s_axi_araddr == OFS_CMD) begin
            s_axi_rdata <= 32'h0;
         end else if (s_axi_araddr == OFS_LEVEL) begin
            s_axi_rdata <= {24'h0, level_ff};
         end else if (s_axi_araddr == OFS_STATUS) begin
            s_axi_rdata <= {28'h0, bus.status};
         end else if (s_axi_araddr == OFS_IDENT) begin
            s_axi_rdata <= {24'h0, ident_ff};
         end else begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : fieldbus_master
`default_nettype wire

// ---- fieldbus_job_command_decoder_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// link watcher
module fieldbus_job_command_decoder_props (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [fieldbus_cmd_pkg::CMD_W-1:0] cmd_pulse,
   input wire logic [fieldbus_cmd_pkg::LVL_W-1:0] cmd_level,
   input wire logic [fieldbus_cmd_pkg::IDENT_W-1:0] ident_data,
   input wire logic [fieldbus_cmd_pkg::STAT_W-1:0] status
);
   import fieldbus_cmd_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // ======================================================
   // properties
   pulse_single_a: assert property (
      |cmd_pulse |=> (cmd_pulse & $past(cmd_pulse)) == 12'h000)
      else $error("command bit held past one cycle");
   run_starts_a: assert property (
      $rose(cmd_pulse[CMD_PULSE_RUN]) && cmd_level[2:0] == 3'h0 && !status[STAT_LOCKED]
      |-> ##3 status[STAT_ROTATING])
      else $error("pulse run did not start rotation");
   rot_idle_a: assert property (
      !status[STAT_ROTATING] && !cmd_pulse[CMD_PULSE_RUN] && !$past(cmd_pulse[CMD_PULSE_RUN])
      && !$past(cmd_pulse[CMD_PULSE_RUN], 2) |=> !status[STAT_ROTATING])
      else $error("rotation began without pulse run");
   block_stops_a: assert property (
      cmd_level[LVL_ROT_BLOCK] [*5] |-> !status[STAT_ROTATING])
      else $error("rotation kept under block");
   block_refuses_a: assert property (
      $rose(cmd_pulse[CMD_PULSE_RUN]) && cmd_level[LVL_ROT_BLOCK] |-> ##3 !status[STAT_ROTATING])
      else $error("start taken under block");
   exit_mode_a: assert property (
      $rose(cmd_pulse[CMD_JOB_EXIT]) |-> ##3 !status[STAT_JOB_MODE] && !status[STAT_JOB_RUN])
      else $error("job exit left job mode on");
   cancel_job_a: assert property (
      $rose(cmd_pulse[CMD_JOB_CANCEL]) |-> ##3 !status[STAT_JOB_RUN])
      else $error("job cancel left job running");
   clear_unlock_a: assert property (
      $rose(cmd_pulse[CMD_TALLY_CLEAR]) |-> ##3 !status[STAT_LOCKED])
      else $error("tally clear kept tool locked");
endmodule : fieldbus_job_command_decoder_props
`default_nettype wire

// ---- fieldbus_job_command_decoder_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module fieldbus_job_command_decoder_test;
   import fieldbus_cmd_pkg::*;
   typedef struct packed {logic [1:0] resp; logic [31:0] data; logic rd;} note_s;
   logic clk, reset_n, multi_spindle_en, line_tally_en, job_continue, batch_complete;
   logic job_request, reverse_dir, process_done, process_timeout;
   logic [7:0] pause_time, identifier_ff, idv;
   logic [15:0] batch_default, batch_count_ff, job_count_ff, bd;
   logic [2:0] selection_source_setting, active_source_ff;
   logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic job_running_ff, tool_locked_ff, job_mode_ff, panel_switch_en, job_pass_ff;
   logic result_dump_ff, seat_sync_ff, rotating_ff, forced_stop_ff, tighten_en_ff;
   logic loosen_en_ff, ident_valid_ff;
   logic [6:0] job_step_ff;
   int n_mismatch, checks_done, i;
   note_s exp_q[$];
   note_s note;
   // ======================================================
   // both ends and the watcher
   fieldbus_if bus();
   fieldbus_master fieldbus_master_inst (.*);
   fieldbus_job_command_decoder fieldbus_job_command_decoder_inst (.*);
   fieldbus_job_command_decoder_props props_inst (.clk(clk), .reset_n(reset_n),
      .cmd_pulse(bus.cmd_pulse), .cmd_level(bus.cmd_level), .ident_data(bus.ident_data),
      .status(bus.status));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ======================================================
   // report
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic hang();
      n_mismatch++;
      $display("unexpected at %0t: no answer", $time);
      tally_and_finish();
   endtask : hang
   // ======================================================
   // axi4-lite master; bready and rready stay high throughout
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      int k;
      @(posedge clk);
      exp_q.push_back('{r, 32'h0, 1'b0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (k = 0; k < 20 && !(s_axi_bvalid && s_axi_bready); k++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      if (k == 20) hang();
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      int k;
      @(posedge clk);
      exp_q.push_back('{r, d, 1'b1});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (k = 0; k < 20 && !(s_axi_rvalid && s_axi_rready); k++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      if (k == 20) hang();
   endtask : rd
   // write, then wait for the three-cycle link latency
   task automatic op(input logic [3:0] a, input logic [31:0] d);
      wr(a, d, RESP_OKAY);
      repeat (2) @(posedge clk);
      #1;
   endtask : op
   task automatic cmd(input int b);
      op(OFS_CMD, 32'h1 << b);
   endtask : cmd
   always @(posedge clk) begin
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
         if (exp_q.size() == 0) hang();
         else begin
            note = exp_q.pop_front();
            check(s_axi_bvalid ? s_axi_bresp : s_axi_rresp, note.resp);
            if (note.rd) check(s_axi_rdata, note.data);
         end
      end
   end
   // ======================================================
   // main sequence
   initial begin
      {reset_n, multi_spindle_en, line_tally_en, job_continue, batch_complete} = 5'h00;
      {job_request, reverse_dir, process_done, process_timeout} = 4'h0;
      pause_time = 8'h00;
      batch_default = 16'h0000;
      selection_source_setting = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      i = $urandom(52);
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      #1;
      check(job_mode_ff, 1);
      check(panel_switch_en, 0);
      rd(OFS_STATUS, 32'h8, RESP_OKAY);
      rd(4'h2, 32'h0, RESP_SLVERR);
      wr(4'h2, 32'hFFFF_FFFF, RESP_SLVERR);
      rd(OFS_CMD, 32'h0, RESP_OKAY);
      $display("reset and map test done");
      cmd(CMD_RESULT_DUMP); check(result_dump_ff, 1);
      cmd(CMD_SEAT_SYNC); check(seat_sync_ff, 0);
      @(posedge clk) pause_time <= 8'($urandom_range(255, 1));
      cmd(CMD_SEAT_SYNC); check(seat_sync_ff, 1);
      @(posedge clk) multi_spindle_en <= 1'b1;
      cmd(CMD_SEAT_SYNC); check(seat_sync_ff, 0);
      @(posedge clk) multi_spindle_en <= 1'b0;
      $display("dump and seat test done");
      bd = 16'($urandom);
      @(posedge clk) batch_default <= bd;
      batch_complete <= 1'b1;
      @(posedge clk) batch_complete <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check(tool_locked_ff, 1);
      cmd(CMD_TALLY_CLEAR); check(batch_count_ff, bd); check(tool_locked_ff, 0);
      cmd(CMD_TALLY_UP); check(batch_count_ff, 16'(bd + 16'h1));
      cmd(CMD_TALLY_DOWN); cmd(CMD_TALLY_DOWN); check(batch_count_ff, 16'(bd - 16'h1));
      $display("tally test done");
      for (i = 0; i < 4; i++) begin
         op(OFS_LEVEL, 32'(i));
         check(tighten_en_ff, !i[0]);
         check(loosen_en_ff, !i[1]);
      end
      op(OFS_LEVEL, 32'h1);
      cmd(CMD_PULSE_RUN); check(rotating_ff, 0);
      @(posedge clk) reverse_dir <= 1'b1;
      cmd(CMD_PULSE_RUN); check(rotating_ff, 1);
      @(posedge clk) process_timeout <= 1'b1;
      @(posedge clk) process_timeout <= 1'b0;
      op(OFS_LEVEL, 32'h2); check(rotating_ff, 0);
      cmd(CMD_PULSE_RUN); check(rotating_ff, 0);
      @(posedge clk) reverse_dir <= 1'b0;
      op(OFS_LEVEL, 32'h0);
      cmd(CMD_PULSE_RUN);
      repeat (5) @(posedge clk);
      #1;
      check(rotating_ff, 1);
      op(OFS_LEVEL, 32'h4); check(forced_stop_ff, 1); check(rotating_ff, 0);
      cmd(CMD_PULSE_RUN); check(rotating_ff, 0);
      op(OFS_LEVEL, 32'h0);
      cmd(CMD_PULSE_RUN);
      @(posedge clk) process_done <= 1'b1;
      @(posedge clk) process_done <= 1'b0;
      #1;
      check(rotating_ff, 0);
      $display("rotation test done");
      @(posedge clk) line_tally_en <= 1'b1;
      job_request <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      check(job_running_ff, 0);
      cmd(CMD_JOB_BEGIN);
      repeat (2) @(posedge clk);
      #1;
      check(job_running_ff, 1);
      @(posedge clk) job_request <= 1'b0;
      cmd(CMD_STEP_SKIP); check(job_step_ff, 7'h01);
      // upper command byte masked off: the skip bit must not reach the link
      @(posedge clk) s_axi_wstrb <= 4'h1;
      cmd(CMD_STEP_SKIP); check(job_step_ff, 7'h01);
      @(posedge clk) s_axi_wstrb <= 4'hF;
      cmd(CMD_TALLY_UP); check(job_count_ff, 16'h0001);
      cmd(CMD_JOB_RERUN); check(job_step_ff, 7'h00); check(job_running_ff, 1);
      check(job_count_ff, 16'h0000);
      @(posedge clk) job_continue <= 1'b1;
      cmd(CMD_STEP_SKIP); check(job_step_ff, 7'h00);
      cmd(CMD_TALLY_UP); check(job_count_ff, 16'h0001); check(batch_count_ff, 16'(bd - 16'h1));
      cmd(CMD_JOB_CANCEL); check(job_pass_ff, 1); check(job_running_ff, 0);
      @(posedge clk) job_request <= 1'b1;
      cmd(CMD_JOB_BEGIN);
      @(posedge clk) job_request <= 1'b0;
      cmd(CMD_JOB_EXIT); check(job_pass_ff, 1); check(job_running_ff, 0);
      check(job_mode_ff, 0); check(panel_switch_en, 1);
      $display("job test done");
      for (i = 0; i < 5; i++) begin
         op(OFS_LEVEL, 32'h8 << i);
         check(active_source_ff, i[2:0]);
      end
      @(posedge clk) selection_source_setting <= 3'($urandom_range(4));
      op(OFS_LEVEL, 32'h18); check(active_source_ff, 3'h0);
      op(OFS_LEVEL, 32'h0); check(active_source_ff, selection_source_setting);
      idv = 8'($urandom);
      op(OFS_LEVEL, 32'h80);
      op(OFS_IDENT, {24'h0, idv});
      rd(OFS_IDENT, {24'h0, idv}, RESP_OKAY);
      cmd(CMD_IDENT_STROBE); check(ident_valid_ff, 1); check(identifier_ff, idv);
      check(job_mode_ff, 1);
      cmd(CMD_JOB_EXIT);
      op(OFS_LEVEL, 32'h40);
      cmd(CMD_JOB_BEGIN); check(job_mode_ff, 1);
      $display("source and identifier test done");
      tally_and_finish();
   end
endmodule : fieldbus_job_command_decoder_test
`default_nettype wire
